// file: verilog/wdrt_top.sv
// Functional notes
// - run enable starts the counter counting up
// - 18-bit up counter advanced by tick
// - interval codes select 2^4..2^18 ticks
// - timeout sets interrupt flag immediately
// - uncleared after 1024 ticks: flag, chip reset
// - reset and reset flag only when enabled
// - clear strobe zeroes counter, self clears
// - chip reset lasts 63 ticks
// - reset flag survives, write one clears
// - timeout in power-down wakes when enabled
// - wake flag set on wake, write-one clears
// - irq flag set only if enabled; W1C
// - clearing run enable resets the counter
// - control writes need unlock from system, except flag write-one clears
// - wake only with internal low-speed rc
`timescale 1ns/1ps
`default_nettype none
module wdrt_top
  import wdrt_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire wdrt_pkg::wdrt_wb_req_t wb_req_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  tick_i,
  input  wire logic                  write_unlock_i,
  input  wire logic                  debug_ack_i,
  input  wire logic                  power_down_i,
  input  wire logic                  internal_low_speed_rc_i,
  output logic                       chip_reset_o,
  output logic                       wake_o,
  output logic                       timeout_irq_o,
  output logic                       irq_o
);
  import wdrt_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // tick and debug come from the slow clock / debugger domain
  logic [2:0] tick_s_q;
  logic [1:0] dbg_s_q;
  logic [1:0] pd_s_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_s_q <= 3'h0;
      dbg_s_q  <= 2'h0;
      pd_s_q   <= 2'h0;
    end
    else
    begin
      tick_s_q <= {tick_s_q[1:0], tick_i};
      dbg_s_q  <= {dbg_s_q[0], debug_ack_i};
      pd_s_q   <= {pd_s_q[0], power_down_i};
    end
  end
  // one enable pulse per rising tick edge, read past the first stage
  logic tick_en;
  assign tick_en = tick_s_q[1] & ~tick_s_q[2];

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  logic acc;
  logic wr;
  logic [31:0] wmask;
  assign acc = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr  = acc & wb_req_i.we;
  assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                  {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

  function automatic logic hit(input logic [7:0] a);
    hit = wr && (wb_req_i.adr == a);
  endfunction

  logic [31:0] wd;
  assign wd = wb_req_i.dat & wmask;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic        run_q;
  logic        irqen_q;
  logic        wken_q;
  logic        rsten_q;
  logic        dbgdis_q;
  logic [2:0]  isel_q;
  logic        clr_q;
  logic        irqf_q;
  logic        rstf_q;
  logic        wkf_q;
  logic        ctrl_wr;
  // protected bits only change while the system unlock is open
  assign ctrl_wr = hit(WDRT_ADDR_CTRL) && write_unlock_i;

  logic [WDRT_CNT_W-1:0] cnt_q;
  logic                  cnt_zero_done;
  assign cnt_zero_done = clr_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q    <= WDRT_CTRL_RESET[WDRT_B_RUN];
      irqen_q  <= WDRT_CTRL_RESET[WDRT_B_IRQEN];
      wken_q   <= WDRT_CTRL_RESET[WDRT_B_WKEN];
      rsten_q  <= WDRT_CTRL_RESET[WDRT_B_RSTEN];
      dbgdis_q <= WDRT_CTRL_RESET[WDRT_B_DBG];
      isel_q   <= WDRT_CTRL_RESET[WDRT_B_IS_LO+:3];
    end
    else if (ctrl_wr)
    begin
      if (wb_req_i.sel[0])
      begin
        run_q   <= wd[WDRT_B_RUN];
        irqen_q <= wd[WDRT_B_IRQEN];
        wken_q  <= wd[WDRT_B_WKEN];
        rsten_q <= wd[WDRT_B_RSTEN];
      end
      if (wb_req_i.sel[1])
        isel_q <= wd[WDRT_B_IS_LO+:3];
      if (wb_req_i.sel[3])
        dbgdis_q <= wd[WDRT_B_DBG];
    end
  end

  // clear strobe: held until the counter has been zeroed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clr_q <= 1'b0;
    else if (ctrl_wr && wb_req_i.sel[0] && wd[WDRT_B_CLR])
      clr_q <= 1'b1;
    else if (cnt_zero_done)
      clr_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // counter and interval decode
  // ------------------------------------------------------------
  function automatic logic [WDRT_CNT_W:0] interval(input logic [2:0] s);
    interval = (WDRT_CNT_W+1)'(1) << (5'd4 + {1'b0, s, 1'b0});
  endfunction

  logic frozen;
  logic step;
  assign frozen = dbg_s_q[1] & ~dbgdis_q;
  assign step   = run_q & tick_en & ~frozen;

  logic timeout;
  assign timeout = step && ({1'b0, cnt_q} + 19'h1 == interval(isel_q));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_q || clr_q)
      cnt_q <= '0;
    else if (step)
      cnt_q <= cnt_q + 18'h1;
  end

  // ------------------------------------------------------------
  // grace delay and chip reset sequencer
  // ------------------------------------------------------------
  wdrt_state_t st_q;
  logic [10:0] gcnt_q;
  logic [5:0]  rcnt_q;
  logic        grace_end;
  logic        rst_done;
  assign grace_end = (st_q == WDRT_GRACE_WAIT) && step && (gcnt_q == WDRT_GRACE - 11'h1);
  assign rst_done  = (st_q == WDRT_CHIP_RESET) && tick_en && (rcnt_q == WDRT_RST_LEN - 6'h1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= WDRT_IDLE;
      gcnt_q <= 11'h0;
      rcnt_q <= 6'h0;
    end
    else
    begin
      case (st_q)
        WDRT_IDLE:
        begin
          gcnt_q <= 11'h0;
          if (timeout)
            st_q <= WDRT_GRACE_WAIT;
        end
        WDRT_GRACE_WAIT:
        begin
          if (!run_q || clr_q)
            st_q <= WDRT_IDLE;
          else if (grace_end)
          begin
            st_q   <= rsten_q ? WDRT_CHIP_RESET : WDRT_IDLE;
            rcnt_q <= 6'h0;
          end
          else if (step)
            gcnt_q <= gcnt_q + 11'h1;
        end
        WDRT_CHIP_RESET:
        begin
          if (rst_done)
            st_q <= WDRT_IDLE;
          else if (tick_en)
            rcnt_q <= rcnt_q + 6'h1;
        end
        default: st_q <= WDRT_IDLE;
      endcase
    end
  end

  logic fire_rst;
  assign fire_rst = grace_end && rsten_q;

  // ------------------------------------------------------------
  // flags: set wins over write-one clear
  // ------------------------------------------------------------
  logic wake_ev;
  assign wake_ev = timeout && wken_q && pd_s_q[1] && internal_low_speed_rc_i;

  logic w1c;
  assign w1c = ctrl_wr || hit(WDRT_ADDR_CTRL);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irqf_q <= 1'b0;
    else if (timeout && irqen_q)
      irqf_q <= 1'b1;
    else if (w1c && wb_req_i.sel[0] && wd[WDRT_B_IRQF])
      irqf_q <= 1'b0;
  end

  // reset flag only cleared by software, never by our chip reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rstf_q <= 1'b0;
    else if (fire_rst)
      rstf_q <= 1'b1;
    else if (w1c && wb_req_i.sel[0] && wd[WDRT_B_RSTF])
      rstf_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wkf_q <= 1'b0;
    else if (wake_ev)
      wkf_q <= 1'b1;
    else if (w1c && wb_req_i.sel[0] && wd[WDRT_B_WKF])
      wkf_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // event status and mask
  // ------------------------------------------------------------
  logic [WDRT_EV_W-1:0] ev;
  logic [WDRT_EV_W-1:0] evst_q;
  logic [WDRT_EV_W-1:0] evmask_q;
  assign ev = {wake_ev, fire_rst, timeout};

  genvar gi;
  generate
    for (gi = 0; gi < WDRT_EV_W; gi++)
    begin : g_ev
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          evst_q[gi] <= 1'b0;
        else if (ev[gi])
          evst_q[gi] <= 1'b1;
        else if (hit(WDRT_ADDR_STATUS) && wd[gi])
          evst_q[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evmask_q <= '0;
    else if (hit(WDRT_ADDR_MASK) && wb_req_i.sel[0])
      evmask_q <= wb_req_i.dat[WDRT_EV_W-1:0];
  end

  // ------------------------------------------------------------
  // outputs, all registered
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chip_reset_o  <= 1'b0;
      wake_o        <= 1'b0;
      timeout_irq_o <= 1'b0;
      irq_o         <= 1'b0;
    end
    else
    begin
      chip_reset_o  <= fire_rst || (st_q == WDRT_CHIP_RESET && !rst_done);
      wake_o        <= wake_ev;
      timeout_irq_o <= (irqf_q || (timeout && irqen_q)) && irqen_q;
      irq_o         <= |((evst_q | ev) & evmask_q);
    end
  end

  // readback
  logic [31:0] ctrl_rd;
  always_comb
  begin
    ctrl_rd = 32'h0;
    ctrl_rd[WDRT_B_DBG]       = dbgdis_q;
    ctrl_rd[WDRT_B_IS_LO+:3]  = isel_q;
    ctrl_rd[WDRT_B_RUN]       = run_q;
    ctrl_rd[WDRT_B_IRQEN]     = irqen_q;
    ctrl_rd[WDRT_B_WKF]       = wkf_q;
    ctrl_rd[WDRT_B_WKEN]      = wken_q;
    ctrl_rd[WDRT_B_IRQF]      = irqf_q;
    ctrl_rd[WDRT_B_RSTF]      = rstf_q;
    ctrl_rd[WDRT_B_RSTEN]     = rsten_q;
    ctrl_rd[WDRT_B_CLR]       = clr_q;
  end

  // single wait-free answer; unmapped addresses read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= acc;
      case (wb_req_i.adr)
        WDRT_ADDR_CTRL:   wb_dat_o <= ctrl_rd;
        WDRT_ADDR_STATUS: wb_dat_o <= {29'h0, evst_q};
        WDRT_ADDR_MASK:   wb_dat_o <= {29'h0, evmask_q};
        WDRT_ADDR_COUNT:  wb_dat_o <= {14'h0, cnt_q};
        default:          wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_count_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_q |=> cnt_q == '0) else $error("counter not held at zero");
  a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    step && !clr_q && !timeout |=> cnt_q == $past(cnt_q) + 18'h1)
    else $error("counter did not step");
  a_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    run_q && frozen && !clr_q |=> $stable(cnt_q)) else $error("counter moved frozen");
  a_clear_auto: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_q |=> !clr_q && cnt_q == '0) else $error("clear strobe stuck");
  a_irq_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    timeout && irqen_q |=> irqf_q) else $error("irq flag not set");
  a_irq_flag_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !irqen_q && !irqf_q |=> !irqf_q) else $error("irq flag set while disabled");
  a_irq_out: assert property (@(posedge clk_i) disable iff (rst_i)
    irqf_q && irqen_q |=> timeout_irq_o) else $error("irq output missing");
  a_reset_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !rsten_q && !rstf_q && !w1c |=> !rstf_q) else $error("reset flag without enable");
  a_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_rst |=> chip_reset_o && rstf_q) else $error("chip reset not raised");
  a_rstf_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    rstf_q && !w1c |=> rstf_q) else $error("reset flag lost");
  a_wake_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !internal_low_speed_rc_i |-> !wake_ev) else $error("wake without rc");
  a_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_ev |=> wake_o && wkf_q) else $error("wake not flagged");
  a_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !write_unlock_i |=> $stable(isel_q) && $stable(run_q)) else $error("locked write");

  c_timeout: cover property (@(posedge clk_i) timeout);
  c_reset: cover property (@(posedge clk_i) fire_rst);
  c_wake: cover property (@(posedge clk_i) wake_ev);
  c_clear_grace: cover property (@(posedge clk_i) st_q == WDRT_GRACE_WAIT && clr_q);

endmodule // wdrt_top
`default_nettype wire

// file: common/wdrt_pkg.sv
package wdrt_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  WDRT_ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  WDRT_ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  WDRT_ADDR_MASK    = 8'h08;
  localparam logic [7:0]  WDRT_ADDR_COUNT   = 8'h0C;
  localparam logic [31:0] WDRT_CTRL_RESET   = 32'h0000_0700;

  // control field positions
  localparam int WDRT_B_CLR   = 0;
  localparam int WDRT_B_RSTEN = 1;
  localparam int WDRT_B_RSTF  = 2;
  localparam int WDRT_B_IRQF  = 3;
  localparam int WDRT_B_WKEN  = 4;
  localparam int WDRT_B_WKF   = 5;
  localparam int WDRT_B_IRQEN = 6;
  localparam int WDRT_B_RUN   = 7;
  localparam int WDRT_B_IS_LO = 8;
  localparam int WDRT_B_DBG   = 31;

  // event status / mask bits
  localparam int WDRT_EV_TIMEOUT = 0;
  localparam int WDRT_EV_RESET   = 1;
  localparam int WDRT_EV_WAKE    = 2;
  localparam int WDRT_EV_W       = 3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int             WDRT_CNT_W    = 18;
  localparam logic [10:0]    WDRT_GRACE    = 11'h400;
  localparam logic [5:0]     WDRT_RST_LEN  = 6'h3F;

  // unlock byte sequence
  localparam logic [7:0] WDRT_KEY0 = 8'h59;
  localparam logic [7:0] WDRT_KEY1 = 8'h16;
  localparam logic [7:0] WDRT_KEY2 = 8'h88;

  typedef enum logic [1:0] {
    WDRT_IDLE,
    WDRT_GRACE_WAIT,
    WDRT_CHIP_RESET
  } wdrt_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wdrt_wb_req_t;

endpackage

// file: verification/wdrt_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdrt_sys_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sleep_req_i,
  input  wire logic wake_i,
  output logic      tick_o,
  output logic      power_down_o
);
  // --------------------------------------------
  // low-speed rc: free running, 8 system clocks
  // --------------------------------------------
  logic [2:0] div_q;
  logic       sleep_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end
  assign tick_o = div_q[2];
  // --------------------------------------------
  // power-down: entered on a request edge, left only on wake
  // --------------------------------------------
  always_ff @(posedge clk_i)
  begin
    sleep_q <= sleep_req_i;
    if (rst_i)
      power_down_o <= 1'b0;
    else if (wake_i)
      power_down_o <= 1'b0;
    else if (sleep_req_i && !sleep_q)
      power_down_o <= 1'b1;
  end
endmodule // wdrt_sys_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdrt_pkg::*;
  logic         clk_i, rst_i, unl, dbg, rc, slp;
  wdrt_wb_req_t req;
  logic [31:0]  dat, q;
  logic         ack, tick, pd, crst, wake, tirq, irq, seen;
  int           errors, samples_checked, n, c;
  int           rows [4][2] = '{'{0, 16}, '{1, 64}, '{2, 256}, '{3, 1024}};

  wdrt_top u_wdrt_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .tick_i(tick), .write_unlock_i(unl), .debug_ack_i(dbg),
    .power_down_i(pd), .internal_low_speed_rc_i(rc), .chip_reset_o(crst),
    .wake_o(wake), .timeout_irq_o(tirq), .irq_o(irq));
  wdrt_sys_model u_wdrt_sys_model (.clk_i(clk_i), .rst_i(rst_i), .sleep_req_i(slp),
    .wake_i(wake), .tick_o(tick), .power_down_o(pd));

  // --------------------------------------------
  // helpers
  // --------------------------------------------
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol = 0);
    samples_checked++;
    if (g !== e && (tol == 0 || $isunknown(g) || g > e + tol || g + tol < e))
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one classic cycle; called just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = dat;
    req <= '0;
    @(posedge clk_i);
    if (k >= 50)
    begin
      errors++;
      summarize();
    end
  endtask

  // counts tick edges until 0: irq, 1: chip reset, 2: power-down left
  task automatic ticks_until(input int s);
    logic p;
    n = 0;
    c = 0;
    p = tick;
    while (!(s == 0 ? tirq : s == 1 ? crst : !pd) && c < 20000)
    begin
      @(posedge clk_i);
      c++;
      if (tick && !p)
        n++;
      p = tick;
    end
    if (c >= 20000)
    begin
      errors++;
      summarize();
    end
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    rst_i = 1'b1;
    req = '0;
    {unl, dbg, slp} = 3'h0;
    rc = 1'b1;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, WDRT_ADDR_CTRL, 32'h0);
    chk(q, 32'h0000_0700);
    chk({crst, tirq, irq, wake}, 32'h0);
    bus(1, WDRT_ADDR_CTRL, 32'h0000_00C0);
    bus(0, WDRT_ADDR_CTRL, 32'h0);
    chk(q, 32'h0000_0700);
    bus(0, 8'h10, 32'h0);
    chk(q, 32'h0);
    $display("reset and lock test done");
    unl <= 1'b1;
    foreach (rows[i])
    begin
      bus(1, WDRT_ADDR_CTRL, {21'h0, rows[i][0][2:0], 8'hC0});
      ticks_until(0);
      chk(n, rows[i][1], 1);
      bus(1, WDRT_ADDR_CTRL, {21'h0, rows[i][0][2:0], 8'hC0});
      chk(tirq, 1);
      bus(1, WDRT_ADDR_MASK, 32'h1);
      chk(irq, 1);
      bus(1, WDRT_ADDR_MASK, 32'h0);
      chk(irq, 0);
      bus(1, WDRT_ADDR_STATUS, 32'h7);
      bus(1, WDRT_ADDR_CTRL, 32'h0000_0048);
      chk(tirq, 0);
      bus(0, WDRT_ADDR_COUNT, 32'h0);
      chk(q, 32'h0);
      $display("interval row %0d done", i);
    end
    bus(1, WDRT_ADDR_CTRL, 32'h0000_0082);
    ticks_until(1);
    chk(n, 1040, 1);
    c = 0;
    while (crst && c < 2000)
    begin
      @(posedge clk_i);
      c++;
    end
    chk(c, 504, 2);
    bus(1, WDRT_ADDR_CTRL, 32'h0);
    bus(0, WDRT_ADDR_CTRL, 32'h0);
    chk(q[2], 1);
    bus(1, WDRT_ADDR_CTRL, 32'h4);
    bus(0, WDRT_ADDR_CTRL, 32'h0);
    chk(q[2], 0);
    $display("chip reset test done");
    bus(1, WDRT_ADDR_CTRL, 32'h0000_0080);
    seen = 1'b0;
    repeat (8800)
    begin
      @(posedge clk_i);
      seen |= crst;
    end
    chk(seen, 0);
    bus(0, WDRT_ADDR_CTRL, 32'h0);
    chk(q[3:2], 0);
    // restart from zero, so that a missed clear would reach the timeout
    bus(1, WDRT_ADDR_CTRL, 32'h0);
    bus(1, WDRT_ADDR_CTRL, 32'h0000_00C0);
    repeat (6)
    begin
      repeat (64) @(posedge clk_i);
      bus(1, WDRT_ADDR_CTRL, 32'h0000_00C1);
    end
    chk(tirq, 0);
    bus(0, WDRT_ADDR_CTRL, 32'h0);
    chk(q[0], 0);
    bus(1, WDRT_ADDR_CTRL, 32'h0);
    $display("clear strobe test done");
    dbg <= 1'b1;
    // freeze must be through the synchroniser before the counter runs
    repeat (2) @(posedge clk_i);
    bus(1, WDRT_ADDR_CTRL, 32'h0000_0080);
    repeat (64) @(posedge clk_i);
    bus(0, WDRT_ADDR_COUNT, 32'h0);
    chk(q, 0);
    bus(1, WDRT_ADDR_CTRL, 32'h8000_0080);
    repeat (80) @(posedge clk_i);
    bus(0, WDRT_ADDR_COUNT, 32'h0);
    chk(q, 10, 1);
    dbg <= 1'b0;
    bus(1, WDRT_ADDR_CTRL, 32'h0);
    $display("debug freeze test done");
    rc <= 1'b0;
    bus(1, WDRT_ADDR_CTRL, 32'h0000_0090);
    slp <= 1'b1;
    repeat (320) @(posedge clk_i);
    chk(pd, 1);
    bus(1, WDRT_ADDR_CTRL, 32'h0);
    rc <= 1'b1;
    bus(1, WDRT_ADDR_CTRL, 32'h0000_0090);
    ticks_until(2);
    chk(n, 16, 1);
    slp <= 1'b0;
    bus(0, WDRT_ADDR_CTRL, 32'h0);
    chk(q[5], 1);
    bus(1, WDRT_ADDR_CTRL, 32'h0000_0020);
    bus(0, WDRT_ADDR_CTRL, 32'h0);
    chk(q[5], 0);
    $display("wake test done");
    summarize();
  end
endmodule // tb
`default_nettype wire
